// file: ascirq_defines.svh
`ifndef ASCIRQ_DEFINES_SVH
`define ASCIRQ_DEFINES_SVH
// bit clock to frame sync ratio and half-frame toggle point
`define ASCIRQ_BITS_PER_FRAME   7'h40
`define ASCIRQ_HALF_FRAME       6'h20
// divider field width and reset value (ratio 2)
`define ASCIRQ_DIV_W            9
`define ASCIRQ_DIV_RESET        9'h001
// fifo level field width
`define ASCIRQ_LVL_W            6
// figures of the clocking scheme, in their own units
`define ASCIRQ_INT_REF_KHZ      12000
`define ASCIRQ_ACLINK_BCLK_KHZ  12288
`define ASCIRQ_NATIVE_RATE_HZ   48000
`define ASCIRQ_MCLK_MHZ         50
`endif

// file: ascirq_pkg.sv
package ascirq_pkg;
    // serial link formats
    typedef enum logic [1:0] {
        ASCIRQ_FMT_I2S_EXT,
        ASCIRQ_FMT_ACLINK,
        ASCIRQ_FMT_INTERNAL
    } ascirq_fmt_e;
    // bit clock generator states
    typedef enum logic [1:0] {
        ASCIRQ_ST_STOPPED,
        ASCIRQ_ST_RUN
    } ascirq_gen_e;
endpackage : ascirq_pkg

// file: ascirq_sync.sv
`include "ascirq_defines.svh"
// three-stage synchroniser; a change counts once stages two and three agree
module ascirq_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    logic out_next;

    // filtered level update
    always_comb begin
        out_next = out_reg;
        if (s2_reg == s3_reg) begin
            out_next = s3_reg;
        end
    end

    // shift chain; first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            s1_reg  <= din;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule : ascirq_sync

// file: ascirq_core.sv
`include "ascirq_defines.svh"
module ascirq_core #(
    parameter int DIV_W = `ASCIRQ_DIV_W,
    parameter int LVL_W = `ASCIRQ_LVL_W,
    parameter int SAMPLE_W = 24
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire ascirq_pkg::ascirq_fmt_e link_format,
    input  wire logic                 bit_clock_direction,
    input  wire logic [DIV_W-1:0]     bit_clock_divider,
    input  wire logic                 bit_clock_stop,
    input  wire logic                 codec_master_clock,
    input  wire logic                 ref_12mhz_in,
    output logic                      ref_12mhz_out,
    input  wire logic                 bit_clock_in,
    output logic                      bit_clock_out,
    output logic                      bit_clock_oe,
    input  wire logic                 channel_select_clock_in,
    output logic                      channel_select_clock_out,
    output logic                      channel_select_clock_oe,
    output logic                      bit_clock_enabled,
    input  wire logic                 serializer_active,
    output logic                      serializer_busy,
    input  wire logic [LVL_W-1:0]     tx_fifo_level,
    input  wire logic [LVL_W-1:0]     rx_fifo_level,
    input  wire logic [LVL_W-1:0]     tx_fifo_threshold,
    input  wire logic [LVL_W-1:0]     rx_fifo_threshold,
    input  wire logic                 tx_fifo_empty,
    input  wire logic                 tx_sample_valid,
    input  wire logic [SAMPLE_W-1:0]  tx_sample,
    input  wire logic                 rx_push_when_full,
    input  wire logic                 underrun_send_last,
    input  wire logic                 tx_slot_strobe,
    output logic [SAMPLE_W-1:0]       tx_link_sample,
    input  wire logic                 cmd_sent_event,
    input  wire logic                 status_rx_event,
    input  wire logic                 status_timeout_event,
    input  wire logic                 clear_tx_underrun,
    input  wire logic                 clear_rx_overrun,
    input  wire logic                 clear_ac_events,
    input  wire logic [6:0]           irq_enable,
    input  wire logic                 tx_dma_enable,
    input  wire logic                 rx_dma_enable,
    output logic                      rx_fifo_service_flag,
    output logic                      tx_fifo_service_flag,
    output logic                      tx_underrun_flag,
    output logic                      rx_overrun_flag,
    output logic                      command_sent_flag,
    output logic                      status_received_flag,
    output logic                      status_read_timeout_flag,
    output logic                      tx_dma_req,
    output logic                      rx_dma_req,
    output logic                      irq
);
    logic                 mclk_sync;
    logic                 bclk_sync;
    logic                 lrclk_sync;
    logic                 mclk_prev_reg;
    logic                 mclk_prev_next;
    logic                 bclk_prev_reg;
    logic                 bclk_prev_next;
    ascirq_pkg::ascirq_gen_e st_reg;
    ascirq_pkg::ascirq_gen_e st_next;
    logic [DIV_W-1:0]     div_reg;
    logic [DIV_W-1:0]     div_next;
    logic [DIV_W-1:0]     cnt_reg;
    logic [DIV_W-1:0]     cnt_next;
    logic                 bclk_reg;
    logic                 bclk_next;
    logic [5:0]           bitcnt_reg;
    logic [5:0]           bitcnt_next;
    logic                 fs_reg;
    logic                 fs_next;
    logic [4:0]           flag_reg;
    logic [4:0]           flag_next;
    logic [SAMPLE_W-1:0]  last_reg;
    logic [SAMPLE_W-1:0]  last_next;
    logic [SAMPLE_W-1:0]  txo_reg;
    logic [SAMPLE_W-1:0]  txo_next;
    logic                 rfs_reg;
    logic                 rfs_next;
    logic                 tfs_reg;
    logic                 tfs_next;
    logic                 master_edge;
    logic                 internal_src;

    // pin inputs from foreign clocks
    ascirq_sync u_sync_mclk (.mclk(mclk), .rst(rst), .din(codec_master_clock), .dout(mclk_sync));
    ascirq_sync u_sync_bclk (.mclk(mclk), .rst(rst), .din(bit_clock_in), .dout(bclk_sync));
    ascirq_sync u_sync_lr   (.mclk(mclk), .rst(rst), .din(channel_select_clock_in),
                             .dout(lrclk_sync));

    // reference passthrough for the internal codec
    assign ref_12mhz_out = (link_format == ascirq_pkg::ASCIRQ_FMT_INTERNAL) ? ref_12mhz_in
                                                                            : 1'b0;
    // bit clock driven only in i2s mode with internal source
    assign internal_src  = (link_format == ascirq_pkg::ASCIRQ_FMT_I2S_EXT) &&
                           bit_clock_direction;
    assign bit_clock_oe  = internal_src && (st_reg == ascirq_pkg::ASCIRQ_ST_RUN);
    assign bit_clock_out = bclk_reg;
    assign channel_select_clock_oe  = bit_clock_oe;
    assign channel_select_clock_out = fs_reg;
    assign bit_clock_enabled = (st_reg == ascirq_pkg::ASCIRQ_ST_RUN);
    assign serializer_busy   = serializer_active || (bitcnt_reg != 6'h00);
    assign master_edge = mclk_sync && !mclk_prev_reg;

    // bit clock divider from the master clock, frame sync by 64
    always_comb begin
        st_next        = st_reg;
        div_next       = div_reg;
        cnt_next       = cnt_reg;
        bclk_next      = bclk_reg;
        bitcnt_next    = bitcnt_reg;
        fs_next        = fs_reg;
        mclk_prev_next = mclk_sync;
        bclk_prev_next = bclk_sync;
        case (st_reg)
            ascirq_pkg::ASCIRQ_ST_STOPPED: begin
                div_next    = bit_clock_divider;
                cnt_next    = '0;
                bclk_next   = 1'b0;
                bitcnt_next = 6'h00;
                fs_next     = 1'b0;
                if (!bit_clock_stop) begin
                    st_next = ascirq_pkg::ASCIRQ_ST_RUN;
                end
            end
            ascirq_pkg::ASCIRQ_ST_RUN: begin
                if (bit_clock_stop) begin
                    // drop the clock at once so it never moves while stopped
                    st_next   = ascirq_pkg::ASCIRQ_ST_STOPPED;
                    bclk_next = 1'b0;
                end else if (internal_src && master_edge) begin
                    // ratio = field + 1, split high/low halves
                    if (cnt_reg == div_reg) begin
                        cnt_next  = '0;
                        bclk_next = 1'b0;
                        bitcnt_next = bitcnt_reg + 6'h01;
                        if (bitcnt_reg == 6'h1f || bitcnt_reg == 6'h3f) begin
                            fs_next = ~fs_reg;
                        end
                    end else begin
                        cnt_next = cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
                        if (cnt_reg == (div_reg >> 1)) begin
                            bclk_next = 1'b1;
                        end
                    end
                end else if (!internal_src) begin
                    // received clocks: count bit clock falls, mirror frame sync
                    fs_next = lrclk_sync;
                    if (!bclk_sync && bclk_prev_reg) begin
                        bitcnt_next = bitcnt_reg + 6'h01;
                    end
                end
            end
            default: st_next = ascirq_pkg::ASCIRQ_ST_STOPPED;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg        <= ascirq_pkg::ASCIRQ_ST_STOPPED;
            div_reg       <= DIV_W'(`ASCIRQ_DIV_RESET);
            cnt_reg       <= '0;
            bclk_reg      <= 1'b0;
            bitcnt_reg    <= 6'h00;
            fs_reg        <= 1'b0;
            mclk_prev_reg <= 1'b0;
            bclk_prev_reg <= 1'b0;
        end else begin
            st_reg        <= st_next;
            div_reg       <= div_next;
            cnt_reg       <= cnt_next;
            bclk_reg      <= bclk_next;
            bitcnt_reg    <= bitcnt_next;
            fs_reg        <= fs_next;
            mclk_prev_reg <= mclk_prev_next;
            bclk_prev_reg <= bclk_prev_next;
        end
    end

    // sticky flags: set wins over clear
    always_comb begin
        flag_next = flag_reg;
        if (clear_tx_underrun) flag_next[0] = 1'b0;
        if (clear_rx_overrun)  flag_next[1] = 1'b0;
        if (clear_ac_events)   flag_next[4:2] = 3'h0;
        if (tx_slot_strobe && tx_fifo_empty) flag_next[0] = 1'b1;
        if (rx_push_when_full) flag_next[1] = 1'b1;
        if (link_format == ascirq_pkg::ASCIRQ_FMT_ACLINK) begin
            if (cmd_sent_event)       flag_next[2] = 1'b1;
            if (status_rx_event)      flag_next[3] = 1'b1;
            if (status_timeout_event) flag_next[4] = 1'b1;
        end
        // fifo service levels from thresholds
        tfs_next = (tx_fifo_level <= tx_fifo_threshold);
        rfs_next = (rx_fifo_level >= rx_fifo_threshold) && (rx_fifo_level != '0);
    end

    // underrun sample: zero or last one sent
    always_comb begin
        last_next = last_reg;
        txo_next  = txo_reg;
        if (tx_slot_strobe) begin
            if (tx_sample_valid) begin
                last_next = tx_sample;
                txo_next  = tx_sample;
            end else begin
                txo_next = underrun_send_last ? last_reg : '0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_reg <= 5'h00;
            tfs_reg  <= 1'b0;
            rfs_reg  <= 1'b0;
            last_reg <= '0;
            txo_reg  <= '0;
        end else begin
            flag_reg <= flag_next;
            tfs_reg  <= tfs_next;
            rfs_reg  <= rfs_next;
            last_reg <= last_next;
            txo_reg  <= txo_next;
        end
    end

    assign tx_link_sample           = txo_reg;
    assign tx_fifo_service_flag     = tfs_reg;
    assign rx_fifo_service_flag     = rfs_reg;
    assign tx_underrun_flag         = flag_reg[0];
    assign rx_overrun_flag          = flag_reg[1];
    assign command_sent_flag        = flag_reg[2];
    assign status_received_flag     = flag_reg[3];
    assign status_read_timeout_flag = flag_reg[4];
    assign tx_dma_req = tfs_reg && tx_dma_enable;
    assign rx_dma_req = rfs_reg && rx_dma_enable;
    // enable bits: 0 rfs,1 tfs,2 tur,3 ror,4 cadt,5 sadr,6 rsto
    assign irq = |({flag_reg[4:0], tfs_reg, rfs_reg} & irq_enable);
endmodule : ascirq_core

// file: ascirq_core_props.sv
`include "ascirq_defines.svh"
// watches the clock pins and status flags of the core
module ascirq_core_props #(
    parameter int LVL_W = `ASCIRQ_LVL_W
) (
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire ascirq_pkg::ascirq_fmt_e link_format,
    input wire logic                    bit_clock_direction,
    input wire logic                    bit_clock_stop,
    input wire logic                    ref_12mhz_in,
    input wire logic                    ref_12mhz_out,
    input wire logic                    bit_clock_out,
    input wire logic                    bit_clock_oe,
    input wire logic                    bit_clock_enabled,
    input wire logic                    tx_fifo_service_flag,
    input wire logic                    tx_dma_enable,
    input wire logic                    tx_dma_req,
    input wire logic [LVL_W-1:0]        tx_fifo_level,
    input wire logic [LVL_W-1:0]        tx_fifo_threshold,
    input wire logic                    tx_slot_strobe,
    input wire logic                    tx_fifo_empty,
    input wire logic                    tx_underrun_flag,
    input wire logic                    rx_push_when_full,
    input wire logic                    rx_overrun_flag,
    input wire logic                    status_timeout_event,
    input wire logic                    status_read_timeout_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // pin may drive only in i2s with internal generation
    wire drv_ok = link_format == ascirq_pkg::ASCIRQ_FMT_I2S_EXT && bit_clock_direction;
    // transmit level at or below its threshold
    wire tfs_cond = tx_fifo_level <= tx_fifo_threshold;
    sequence s_held_stop;
        bit_clock_stop [*3];
    endsequence
    property p_ref;
        ref_12mhz_out == (link_format == ascirq_pkg::ASCIRQ_FMT_INTERNAL && ref_12mhz_in);
    endproperty
    a_ref: assert property (p_ref) else $error("reference clock wrong");
    // pin driven only while running, one cycle after stop is released
    property p_oe;
        bit_clock_oe == (drv_ok && !$past(bit_clock_stop) && !$past(rst));
    endproperty
    a_oe: assert property (p_oe) else $error("bit clock driven wrongly");
    property p_en;
        bit_clock_enabled == (!$past(bit_clock_stop) && !$past(rst));
    endproperty
    a_en: assert property (p_en) else $error("enable state wrong");
    property p_hold;
        s_held_stop |-> $stable(bit_clock_out);
    endproperty
    a_hold: assert property (p_hold) else $error("bit clock moved while stopped");
    // request follows the registered level compare, gated by its enable
    property p_dma;
        tx_dma_req == (tx_dma_enable && !$past(rst) && $past(tfs_cond));
    endproperty
    a_dma: assert property (p_dma) else $error("tx dma request wrong");
    property p_tur;
        tx_slot_strobe && tx_fifo_empty |=> tx_underrun_flag;
    endproperty
    a_tur: assert property (p_tur) else $error("underrun not flagged");
    property p_ror;
        rx_push_when_full |=> rx_overrun_flag;
    endproperty
    a_ror: assert property (p_ror) else $error("overrun not flagged");
    property p_rsto;
        status_timeout_event && link_format == ascirq_pkg::ASCIRQ_FMT_ACLINK
            |=> status_read_timeout_flag;
    endproperty
    a_rsto: assert property (p_rsto) else $error("timeout not flagged");
endmodule : ascirq_core_props

bind ascirq_core ascirq_core_props ascirq_core_props_inst (.*);

// file: ascirq_codec_model.sv
// codec side: free master clock, bit clock only while run is high
module ascirq_codec_model (
    input  wire logic bclk_run,
    output logic      codec_master_clock,
    output logic      bit_clock_in,
    output logic      channel_select_clock_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int n;
    // bit clock is four master clocks, sync is bit clock over 64
    initial begin
        {codec_master_clock, bit_clock_in, channel_select_clock_in} = '0;
        n = 0;
        forever begin
            #80 codec_master_clock = ~codec_master_clock;
            if (codec_master_clock && bclk_run) begin
                n++;
                if (n % 2 == 0) bit_clock_in = ~bit_clock_in;
                if (n % 128 == 0) channel_select_clock_in = ~channel_select_clock_in;
            end
        end
    end
endmodule : ascirq_codec_model

// file: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    ascirq_pkg::ascirq_fmt_e link_format;
    logic mclk = 1'b0, rst, bit_clock_direction, bit_clock_stop, codec_master_clock;
    logic ref_12mhz_in, bit_clock_in, channel_select_clock_in, serializer_active, bclk_run;
    logic tx_fifo_empty, tx_sample_valid, rx_push_when_full, underrun_send_last;
    logic tx_slot_strobe, cmd_sent_event, status_rx_event, status_timeout_event;
    logic clear_tx_underrun, clear_rx_overrun, clear_ac_events, tx_dma_enable;
    logic rx_dma_enable, ref_12mhz_out, bit_clock_out, bit_clock_oe, ac;
    logic channel_select_clock_out, channel_select_clock_oe, bit_clock_enabled;
    logic serializer_busy, rx_fifo_service_flag, tx_fifo_service_flag, tx_underrun_flag;
    logic rx_overrun_flag, command_sent_flag, status_received_flag;
    logic status_read_timeout_flag, tx_dma_req, rx_dma_req, irq;
    logic [8:0] bit_clock_divider;
    logic [5:0] tx_fifo_level, rx_fifo_level, tx_fifo_threshold, rx_fifo_threshold;
    logic [23:0] tx_sample, tx_link_sample, ls, xs;
    logic [6:0] irq_enable, ef;
    logic [1:0] ed;
    logic [31:0] r;
    integer seed;
    int miscompares, num_checks, i, d, t0, t1;
    int divq[$] = '{1, 3, 5, 7, 11};
    wire [6:0] flags = {status_read_timeout_flag, status_received_flag, command_sent_flag,
        rx_overrun_flag, tx_underrun_flag, tx_fifo_service_flag, rx_fifo_service_flag};
    wire [1:0] dreq = {tx_dma_req, rx_dma_req};
    ascirq_core ascirq_core_inst (.*);
    ascirq_codec_model ascirq_codec_model_inst (.*);
    // 50 MHz clock
    always #10 mclk = ~mclk;
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (exp !== got) begin
            miscompares++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask : cmp
    task automatic step(int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : step
    // bounded wait for a bit clock rise or any frame sync change
    task automatic wait_edge(bit sel, output int t);
        logic p, v;
        int k;
        p = sel ? channel_select_clock_out : bit_clock_out;
        for (k = 0; k < 9000; k++) begin
            step(1);
            v = sel ? channel_select_clock_out : bit_clock_out;
            if (p !== v && (sel || v === 1'b1)) break;
            p = v;
        end
        if (k < 9000) t = $time / 20;
        else begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_edge
    // bounded wait until the serializer reports idle
    task automatic wait_idle;
        int k;
        for (k = 0; k < 9000 && serializer_busy !== 1'b0; k++) begin
            step(1);
        end
        if (k == 9000) begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_idle
    // main sequence
    initial begin
        seed = 32'h8b43;
        rst = 1'b1;
        link_format = ascirq_pkg::ASCIRQ_FMT_I2S_EXT;
        bit_clock_divider = 9'h001;
        {bit_clock_direction, bit_clock_stop, ref_12mhz_in, serializer_active, bclk_run} = '0;
        {tx_fifo_empty, tx_sample_valid, rx_push_when_full, underrun_send_last} = '0;
        {tx_slot_strobe, cmd_sent_event, status_rx_event, status_timeout_event} = '0;
        {clear_tx_underrun, clear_rx_overrun, clear_ac_events, tx_dma_enable} = '0;
        {rx_dma_enable, tx_fifo_level, rx_fifo_level, irq_enable, ef} = '0;
        {tx_fifo_threshold, rx_fifo_threshold, tx_sample, ls} = '0;
        step(6);
        rst = 1'b0;
        bit_clock_direction = 1'b1;
        foreach (divq[j]) begin
            d = divq[j];
            wait_idle();
            bit_clock_stop = 1'b1;
            step(4);
            bit_clock_divider = 9'(d);
            step(40);
            cmp("stopped bit clock", 0, bit_clock_out);
            cmp("bit clock enabled", 0, bit_clock_enabled);
            bit_clock_stop = 1'b0;
            wait_edge(0, t0);
            wait_edge(0, t0);
            wait_edge(0, t1);
            cmp("bit clock period", (d + 1) * 8, t1 - t0);
            bit_clock_divider = 9'(d + 2);
            wait_edge(1, t0);
            wait_edge(1, t0);
            wait_edge(1, t1);
            cmp("frame half period", 32 * (d + 1) * 8, t1 - t0);
            cmp("bit clock oe", 1, bit_clock_oe);
            cmp("bit clock enabled", 1, bit_clock_enabled);
        end
        // codec supplies the clocks: frame sync follows the received one
        wait_idle();
        bit_clock_stop = 1'b1;
        step(4);
        bit_clock_direction = 1'b0;
        bclk_run = 1'b1;
        step(2);
        bit_clock_stop = 1'b0;
        wait_edge(1, t0);
        wait_edge(1, t0);
        wait_edge(1, t1);
        cmp("received frame half period", 32 * 4 * 8, t1 - t0);
        cmp("bit clock oe", 0, bit_clock_oe);
        // every source change goes through the stop procedure
        for (i = 0; i < 6; i++) begin
            wait_idle();
            bit_clock_stop = 1'b1;
            step(2);
            link_format = ascirq_pkg::ascirq_fmt_e'(i % 3);
            bit_clock_direction = i[0];
            ref_12mhz_in = ~i[1];
            step(2);
            bit_clock_stop = 1'b0;
            step(8);
            ac = link_format == ascirq_pkg::ASCIRQ_FMT_INTERNAL;
            cmp("reference out", ac & ref_12mhz_in, ref_12mhz_out);
            cmp("bit clock oe", (i % 3 == 0) && i[0], bit_clock_oe);
            cmp("frame sync oe", (i % 3 == 0) && i[0], channel_select_clock_oe);
        end
        // status phase runs with the bit clock stopped and the counter idle
        wait_idle();
        bit_clock_stop = 1'b1;
        step(2);
        for (i = 0; i < 400; i++) begin
            ac = i[6];
            link_format = ac ? ascirq_pkg::ASCIRQ_FMT_ACLINK : ascirq_pkg::ASCIRQ_FMT_I2S_EXT;
            r = $random(seed);
            {tx_fifo_level, rx_fifo_level, tx_fifo_threshold, rx_fifo_threshold} = r[23:0];
            r = $random(seed);
            {tx_slot_strobe, tx_fifo_empty, rx_push_when_full, cmd_sent_event} = r[3:0] & r[7:4];
            {status_rx_event, status_timeout_event, clear_tx_underrun} = r[10:8] & r[13:11];
            {clear_rx_overrun, clear_ac_events, tx_dma_enable, rx_dma_enable} = r[17:14];
            {irq_enable, underrun_send_last, tx_sample_valid, serializer_active} = r[27:18];
            tx_sample = 24'($random(seed));
            ef[0] = rx_fifo_level >= rx_fifo_threshold && rx_fifo_level != 0;
            ef[1] = tx_fifo_level <= tx_fifo_threshold;
            ef[2] = tx_slot_strobe && tx_fifo_empty || ef[2] && !clear_tx_underrun;
            ef[3] = rx_push_when_full || ef[3] && !clear_rx_overrun;
            ef[4] = ac && cmd_sent_event || ef[4] && !clear_ac_events;
            ef[5] = ac && status_rx_event || ef[5] && !clear_ac_events;
            ef[6] = ac && status_timeout_event || ef[6] && !clear_ac_events;
            ed = {ef[1] & tx_dma_enable, ef[0] & rx_dma_enable};
            // slot sample: new one, else zero or the last one sent
            if (tx_slot_strobe) begin
                xs = tx_sample_valid ? tx_sample : (underrun_send_last ? ls : 24'h0);
                if (tx_sample_valid) ls = tx_sample;
            end
            step(1);
            cmp("status flags", ef, flags);
            cmp("interrupt", |(ef & irq_enable), irq);
            cmp("dma requests", ed, dreq);
            cmp("serializer busy", serializer_active, serializer_busy);
            if (tx_slot_strobe) cmp("link sample", xs, tx_link_sample);
        end
        give_verdict();
    end
endmodule : tb
